// ---- inc/plfp_pkg.sv ----
/*
  Shared constants for the power line frame protocol kernel: frame field
  values, character timing, buffer depth and tick timing.
  Assumes a 200 MHz system clock.
*/
package plfp_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD = 1200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam logic [7:0] PREAMBLE_VAL = 8'hFF;
  localparam logic [7:0] HEADER_VAL = 8'hAA;
  localparam int unsigned BUF_DEPTH = 16;
  localparam int unsigned CHAR_BITS = 11;
  // Tick period in nanoseconds, figure as printed
  localparam real TICK_NS = 555560.0;
  localparam int unsigned TICK_CYCLES = 111112;
  // Watchdog kick low time: at least 500 ns
  localparam int unsigned KICK_NS = 500;
  localparam int unsigned KICK_CYCLES = (KICK_NS * 200 + 999) / 1000;
  localparam logic [7:0] FCS_INIT = 8'h00;
  localparam int unsigned HDR_FIELDS = 4;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_HDR, TX_FLD, TX_DATA, TX_FCS, TX_WAIT} tx_state_t;
  typedef enum logic [1:0] {RX_HUNT, RX_FLD, RX_DATA, RX_FCS} rx_state_t;
endpackage

// ---- design/power_line_frame_protocol.sv ----
/*
  Frame kernel for a power line FSK modem on an 11-bit async serial link.
  Assumes synchronous inputs; the modem keeps its own watchdog and
  direction timeout.
*/
`timescale 1ns/1ps
// How it works
// R1 - Frame fields sent in fixed order
// R2 - Preamble is FFh
// R3 - Header AAh marks frame start
// R4 - Drop frames with foreign house address
// R5 - Start, 8 data, odd parity, stop
// R6 - 1200 baud both ways
// R7 - Append checksum, verify on receive
// R8 - Transmit starts by loading preamble
// R9 - Empty event after each sent byte
// R10 - Compare match event on programmable value
// R11 - Receive data event per byte
// R12 - Sixteen entry transmit and receive buffers
// R13 - Tick updates timing, kicks watchdog
// R14 - Direction low means transmit
// R15 - Watchdog pulses low, periodic
// R16 - Tick every 555.56 microseconds
// R17 - Carrier detect falling edge events
// R18 - Modulo-256 checksum, drop parity errors
module power_line_frame_protocol #(
  parameter int unsigned TICK_CYC = plfp_pkg::TICK_CYCLES,
  // Clocks per serial bit; a short value lets a bench finish whole frames
  parameter int unsigned BIT_CYC = plfp_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] house_addr,
  input wire logic [7:0] compare_value,
  input wire logic [7:0] link_ctrl,
  input wire logic [7:0] src_addr,
  input wire logic [7:0] dst_addr,
  input wire logic [4:0] tx_len,
  input wire logic tx_wr,
  input wire logic [3:0] tx_wr_idx,
  input wire logic [7:0] tx_wr_data,
  input wire logic tx_start,
  output logic tx_busy,
  input wire logic [3:0] rx_rd_idx,
  output logic [7:0] rx_rd_data,
  output logic [4:0] rx_len,
  output logic rx_frame_ok,
  output logic rx_frame_bad,
  input wire logic serial_in,
  output logic serial_out,
  output logic rx_tx_n,
  output logic modem_watchdog_kick,
  input wire logic carrier_sense_n,
  output logic carrier_event,
  output logic tx_holding_empty_event,
  output logic rx_compare_match_event,
  output logic rx_data_event,
  output logic tick,
  output logic [15:0] tick_count
);
  import plfp_pkg::*;

  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~^d;
  endfunction

  logic [7:0] tx_buf [BUF_DEPTH];
  logic [7:0] rx_buf [BUF_DEPTH];

  // Tick generator and watchdog kick pulse
  logic [16:0] tick_cnt_r;
  logic [7:0] kick_cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
      tick <= 1'b0;
      tick_count <= '0;
    end else begin
      tick <= 1'b0;
      if (tick_cnt_r == 17'(TICK_CYC - 1)) begin // see R16
        tick_cnt_r <= '0;
        tick <= 1'b1;
        tick_count <= tick_count + 16'h0001; // see R13
      end else begin
        tick_cnt_r <= tick_cnt_r + 17'h0_0001;
      end
    end
  end

  // Low pulse on each tick keeps the modem out of reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_cnt_r <= '0;
      modem_watchdog_kick <= 1'b1;
    end else if (tick) begin
      kick_cnt_r <= 8'(KICK_CYCLES);
      modem_watchdog_kick <= 1'b0; // see R13 see R15
    end else if (kick_cnt_r != 8'h00) begin
      kick_cnt_r <= kick_cnt_r - 8'h01;
      modem_watchdog_kick <= (kick_cnt_r == 8'h01);
    end
  end

  // Carrier detect edge
  logic cs_d_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_d_r <= 1'b1;
      carrier_event <= 1'b0;
    end else begin
      cs_d_r <= carrier_sense_n;
      carrier_event <= cs_d_r & ~carrier_sense_n; // see R17
    end
  end

  // Transmit buffer writes from the user side
  always_ff @(posedge clk) begin
    if (tx_wr) begin
      tx_buf[tx_wr_idx] <= tx_wr_data; // see R12
    end
  end

  // Serial transmitter: one 11-bit character per load
  logic [10:0] tsh_r;
  logic [3:0] tbit_r;
  logic [17:0] tbaud_r;
  logic tload;
  logic [7:0] tbyte;
  logic tactive_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tsh_r <= '1;
      tbit_r <= '0;
      tbaud_r <= '0;
      tactive_r <= 1'b0;
      tx_holding_empty_event <= 1'b0;
    end else begin
      tx_holding_empty_event <= 1'b0;
      if (tload) begin
        tsh_r <= {1'b1, odd_par(tbyte), tbyte, 1'b0}; // see R5
        tbit_r <= '0;
        tbaud_r <= '0;
        tactive_r <= 1'b1;
      end else if (tactive_r) begin
        if (tbaud_r == 18'(BIT_CYC - 1)) begin // see R6
          tbaud_r <= '0;
          tsh_r <= {1'b1, tsh_r[10:1]};
          if (tbit_r == 4'(CHAR_BITS - 1)) begin
            tactive_r <= 1'b0;
            tx_holding_empty_event <= 1'b1; // see R9
          end else begin
            tbit_r <= tbit_r + 4'h1;
          end
        end else begin
          tbaud_r <= tbaud_r + 18'h0_0001;
        end
      end
    end
  end
  assign serial_out = tsh_r[0];

  // Transmit frame sequencer
  tx_state_t ts_r;
  logic [4:0] tidx_r;
  logic [7:0] tsum_r;
  logic [7:0] fld;
  always_comb begin
    case (tidx_r[1:0])
      2'd0: fld = house_addr;
      2'd1: fld = link_ctrl;
      2'd2: fld = src_addr;
      default: fld = dst_addr;
    endcase
  end
  always_comb begin
    tload = 1'b0;
    tbyte = PREAMBLE_VAL;
    case (ts_r)
      TX_PRE: begin
        tload = 1'b1;
        tbyte = PREAMBLE_VAL; // see R2 see R8
      end
      TX_HDR: begin
        tload = tx_holding_empty_event;
        tbyte = HEADER_VAL; // see R3
      end
      TX_FLD: begin
        tload = tx_holding_empty_event;
        tbyte = fld;
      end
      TX_DATA: begin
        tload = tx_holding_empty_event;
        tbyte = tx_buf[tidx_r[3:0]];
      end
      TX_FCS: begin
        tload = tx_holding_empty_event;
        tbyte = tsum_r; // see R7
      end
      default: begin
        tload = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_r <= TX_IDLE;
      tidx_r <= '0;
      tsum_r <= FCS_INIT;
    end else begin
      case (ts_r)
        TX_IDLE: if (tx_start) begin
          ts_r <= TX_PRE;
        end
        TX_PRE: ts_r <= TX_HDR;
        TX_HDR: if (tload) begin
          ts_r <= TX_FLD; // see R1
          tidx_r <= '0;
          tsum_r <= FCS_INIT;
        end
        TX_FLD: if (tload) begin
          tsum_r <= tsum_r + tbyte; // see R18
          tidx_r <= tidx_r + 5'h01;
          if (tidx_r == 5'(HDR_FIELDS - 1)) begin
            tidx_r <= '0;
            ts_r <= (tx_len == 5'h00) ? TX_FCS : TX_DATA;
          end
        end
        TX_DATA: if (tload) begin
          tsum_r <= tsum_r + tbyte;
          tidx_r <= tidx_r + 5'h01;
          if (tidx_r + 5'h01 >= tx_len || tidx_r == 5'(BUF_DEPTH - 1)) begin
            ts_r <= TX_FCS;
          end
        end
        TX_FCS: if (tload) begin
          ts_r <= TX_WAIT;
        end
        TX_WAIT: if (tx_holding_empty_event) begin
          ts_r <= TX_IDLE;
        end
        default: ts_r <= TX_IDLE;
      endcase
    end
  end
  assign tx_busy = (ts_r != TX_IDLE);
  assign rx_tx_n = ~tx_busy; // see R14

  // Serial receiver, samples mid-bit
  logic [3:0] rbit_r;
  logic [17:0] rbaud_r;
  logic ractive_r;
  logic [8:0] rsh_r;
  logic [7:0] rbyte_r;
  logic rpar_err_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rbit_r <= '0;
      rbaud_r <= '0;
      ractive_r <= 1'b0;
      rsh_r <= '0;
      rbyte_r <= '0;
      rpar_err_r <= 1'b0;
      rx_data_event <= 1'b0;
      rx_compare_match_event <= 1'b0;
    end else begin
      rx_data_event <= 1'b0;
      rx_compare_match_event <= 1'b0;
      if (!ractive_r) begin
        if (!serial_in) begin
          ractive_r <= 1'b1;
          rbaud_r <= 18'(BIT_CYC / 2);
          rbit_r <= '0;
        end
      end else if (rbaud_r == 18'(BIT_CYC - 1)) begin // see R6
        rbaud_r <= '0;
        rbit_r <= rbit_r + 4'h1;
        if (rbit_r == 4'h0 && serial_in) begin
          ractive_r <= 1'b0; // False start
        end else if (rbit_r >= 4'h1 && rbit_r <= 4'h9) begin
          rsh_r <= {serial_in, rsh_r[8:1]}; // see R5
        end else if (rbit_r == 4'(CHAR_BITS - 1)) begin
          ractive_r <= 1'b0;
          rbyte_r <= rsh_r[7:0];
          rpar_err_r <= (rsh_r[8] != odd_par(rsh_r[7:0])) | ~serial_in;
          rx_data_event <= 1'b1; // see R11
          rx_compare_match_event <= (rsh_r[7:0] == compare_value); // see R10
        end
      end else begin
        rbaud_r <= rbaud_r + 18'h0_0001;
      end
    end
  end

  // Receive frame analysis; hunt waits for the compare match on the header
  rx_state_t rs_r;
  logic [2:0] rf_r;
  logic [7:0] rsum_r;
  logic [4:0] rcnt_r;
  logic [4:0] rexp_r;
  logic rbad_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rs_r <= RX_HUNT;
      rf_r <= '0;
      rsum_r <= FCS_INIT;
      rcnt_r <= '0;
      rexp_r <= '0;
      rbad_r <= 1'b0;
      rx_frame_ok <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_len <= '0;
    end else begin
      rx_frame_ok <= 1'b0;
      rx_frame_bad <= 1'b0;
      if (rx_data_event) begin
        case (rs_r)
          RX_HUNT: if (rx_compare_match_event && !rpar_err_r) begin // see R3 see R10
            rs_r <= RX_FLD;
            rf_r <= '0;
            rsum_r <= FCS_INIT;
            rbad_r <= 1'b0;
            rcnt_r <= '0;
          end
          RX_FLD: begin
            rsum_r <= rsum_r + rbyte_r;
            rf_r <= rf_r + 3'h1;
            if (rpar_err_r) rbad_r <= 1'b1; // see R18
            if (rf_r == 3'h0 && rbyte_r != house_addr) rbad_r <= 1'b1; // see R4
            // Low five bits of link control carry the data length
            if (rf_r == 3'h1) rexp_r <= (rbyte_r[4:0] > 5'(BUF_DEPTH)) ?
                                        5'(BUF_DEPTH) : rbyte_r[4:0];
            if (rf_r == 3'(HDR_FIELDS - 1)) rs_r <= (rexp_r == 5'h00) ? RX_FCS : RX_DATA;
          end
          RX_DATA: begin
            rsum_r <= rsum_r + rbyte_r;
            rcnt_r <= rcnt_r + 5'h01;
            if (rpar_err_r) rbad_r <= 1'b1;
            if (rcnt_r + 5'h01 >= rexp_r) rs_r <= RX_FCS;
          end
          RX_FCS: begin
            rs_r <= RX_HUNT;
            rx_len <= rcnt_r;
            if (rbad_r || rpar_err_r || rbyte_r != rsum_r) begin // see R7
              rx_frame_bad <= 1'b1;
            end else begin
              rx_frame_ok <= 1'b1;
            end
          end
          default: rs_r <= RX_HUNT;
        endcase
      end
    end
  end
  // Receive buffer kept out of the reset process: the memory has no reset
  always_ff @(posedge clk) begin
    if (rx_data_event && rs_r == RX_DATA) begin
      rx_buf[rcnt_r[3:0]] <= rbyte_r; // see R12
    end
  end
  assign rx_rd_data = rx_buf[rx_rd_idx];

  // Checks
  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_b) // see R16
    tick |=> !tick [*8]) else $error("tick repeated too soon");
  a_kick_low: assert property (@(posedge clk) disable iff (!rst_b) // see R13
    tick |=> !modem_watchdog_kick) else $error("watchdog kick not low after tick");
  // A low line level means a character is out, so the modem must be in transmit
  a_dir_tx: assert property (@(posedge clk) disable iff (!rst_b) // see R14
    !serial_out |-> !rx_tx_n) else $error("line driven low in receive direction");
  a_pre_first: assert property (@(posedge clk) disable iff (!rst_b) // see R8
    (ts_r == TX_PRE) |-> tload && tbyte == PREAMBLE_VAL) else $error("preamble not first");
  a_start_bit: assert property (@(posedge clk) disable iff (!rst_b) // see R5
    tload |=> !serial_out) else $error("no start bit");
  a_match_data: assert property (@(posedge clk) disable iff (!rst_b) // see R10
    rx_compare_match_event |-> rx_data_event) else $error("match without data");
  // Verdict only straight after the check-sum character was taken
  a_fcs_one: assert property (@(posedge clk) disable iff (!rst_b) // see R7
    (rx_frame_ok || rx_frame_bad) |-> $past(rx_data_event) && $past(rs_r) == RX_FCS)
    else $error("frame verdict outside check-sum slot");
  a_carrier_edge: assert property (@(posedge clk) disable iff (!rst_b) // see R17
    carrier_event |-> $past(cs_d_r) && !$past(carrier_sense_n))
    else $error("carrier event without falling edge");
  c_frame_ok: cover property (@(posedge clk) disable iff (!rst_b) rx_frame_ok);
  c_frame_bad: cover property (@(posedge clk) disable iff (!rst_b) rx_frame_bad);
  c_tx_done: cover property (@(posedge clk) disable iff (!rst_b)
    (ts_r == TX_WAIT) ##1 (ts_r == TX_IDLE));
endmodule

// ---- tb/modem_model.sv ----
/*
  Behavioural model of the power line FSK modem at the far side of the kernel.
  Assumes one clock shared with the kernel; time limits are scaled to cycles.
*/
`timescale 1ns/1ps
module modem_model #(
  parameter int unsigned WD_LIMIT = 1000,
  parameter int unsigned DIR_LIMIT = 4000,
  parameter int unsigned MIN_LOW = 100,
  parameter int unsigned BIT = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_out,
  input wire logic rx_tx_n,
  input wire logic modem_watchdog_kick,
  input wire logic carrier_cmd,
  output logic serial_in,
  output logic carrier_sense_n,
  output logic modem_reset_out,
  output logic short_kick,
  output logic dir_timeout
);
  int unsigned since_kick_r;
  int unsigned low_len_r;
  int unsigned dir_len_r;
  logic kick_d_r;
  logic line_r = 1'b1;

  // Receive line idles high between the characters that send_char puts out
  assign serial_in = line_r;
  // Carrier detect is active low while the test asks for a carrier
  assign carrier_sense_n = ~carrier_cmd;

  // Watchdog: falling kick restarts the timeout, short low pulses are flagged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_kick_r <= 0;
      low_len_r <= 0;
      kick_d_r <= 1'b1;
      modem_reset_out <= 1'b0;
      short_kick <= 1'b0;
    end else begin
      kick_d_r <= modem_watchdog_kick;
      since_kick_r <= (kick_d_r && !modem_watchdog_kick) ? 0 : since_kick_r + 1;
      low_len_r <= modem_watchdog_kick ? 0 : low_len_r + 1;
      if (since_kick_r > WD_LIMIT) begin
        modem_reset_out <= 1'b1;
      end
      if (!kick_d_r && modem_watchdog_kick && low_len_r < MIN_LOW) begin
        short_kick <= 1'b1;
      end
    end
  end

  // Direction: the modem falls back to receive if transmit is held too long
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_len_r <= 0;
      dir_timeout <= 1'b0;
    end else begin
      dir_len_r <= rx_tx_n ? 0 : dir_len_r + 1;
      if (dir_len_r > DIR_LIMIT) begin
        dir_timeout <= 1'b1;
      end
    end
  end

  // One 11-bit character to the kernel, LSB first; par_flip spoils the parity
  task automatic send_char(input logic [7:0] b, input logic par_flip);
    logic [10:0] f;
    f = {1'b1, (~^b) ^ par_flip, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_r <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask

  // One character from the kernel, each bit sampled in its middle; returns at mid-stop
  task automatic recv_char(output logic [7:0] b, output logic good);
    logic [9:0] s;
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 20 * BIT) begin
      @(negedge clk);
      n++;
    end
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(negedge clk);
      s[i] = serial_out;
    end
    b = s[7:0];
    good = (s[8] === ~^s[7:0]) && (s[9] === 1'b1) && (n < 20 * BIT);
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the frame kernel with the modem model attached.
  Assumes shortened tick and bit periods so that whole frames fit in one run.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  import plfp_pkg::*;
  localparam int unsigned TICKS = 200;
  localparam int unsigned BIT = 16;
  logic clk = 1'b0, rst_b = 1'b0, tx_wr = 1'b0, tx_start = 1'b0, carrier_cmd = 1'b0;
  logic [7:0] house_addr = 8'h5A, link_ctrl = 8'h02, src_addr = 8'h11, dst_addr = 8'h22;
  logic [7:0] compare_value = HEADER_VAL, tx_wr_data = 8'h00, rx_rd_data;
  logic [3:0] tx_wr_idx = 4'h0, rx_rd_idx = 4'h0;
  logic [4:0] tx_len = 5'h00, rx_len;
  logic [15:0] tick_count;
  logic tx_busy, rx_frame_ok, rx_frame_bad, serial_in, serial_out, rx_tx_n, kick;
  logic carrier_sense_n, carrier_event, empty_ev, match_ev, rx_data_event, tick;
  logic modem_reset_out, short_kick, dir_timeout;
  int n_fail = 0, samples_checked = 0;
  int n_empty = 0, n_data = 0, n_match = 0, n_ok = 0, n_bad = 0;

  power_line_frame_protocol #(.TICK_CYC(TICKS), .BIT_CYC(BIT)) dut_u (.clk(clk), .rst_b(rst_b),
    .house_addr(house_addr), .compare_value(compare_value), .link_ctrl(link_ctrl),
    .src_addr(src_addr), .dst_addr(dst_addr), .tx_len(tx_len), .tx_wr(tx_wr),
    .tx_wr_idx(tx_wr_idx), .tx_wr_data(tx_wr_data), .tx_start(tx_start),
    .tx_busy(tx_busy), .rx_rd_idx(rx_rd_idx), .rx_rd_data(rx_rd_data), .rx_len(rx_len),
    .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad), .serial_in(serial_in),
    .serial_out(serial_out), .rx_tx_n(rx_tx_n), .modem_watchdog_kick(kick),
    .carrier_sense_n(carrier_sense_n), .carrier_event(carrier_event),
    .tx_holding_empty_event(empty_ev), .rx_compare_match_event(match_ev),
    .rx_data_event(rx_data_event), .tick(tick), .tick_count(tick_count));

  modem_model #(.BIT(BIT)) modem_u (.clk(clk), .rst_b(rst_b), .serial_out(serial_out),
    .rx_tx_n(rx_tx_n), .modem_watchdog_kick(kick), .carrier_cmd(carrier_cmd),
    .serial_in(serial_in), .carrier_sense_n(carrier_sense_n),
    .modem_reset_out(modem_reset_out), .short_kick(short_kick), .dir_timeout(dir_timeout));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // One-cycle events tallied between edges, where they have settled
  always @(negedge clk) begin
    n_empty <= n_empty + (empty_ev === 1'b1);
    n_data <= n_data + (rx_data_event === 1'b1);
    n_match <= n_match + (match_ev === 1'b1);
    n_ok <= n_ok + (rx_frame_ok === 1'b1);
    n_bad <= n_bad + (rx_frame_bad === 1'b1);
  end

  // Expected frame: preamble, header, fields, two data bytes, mod-256 sum
  function automatic logic [7:0] frame_byte(input int i, input logic [7:0] hs);
    case (i)
      0: frame_byte = PREAMBLE_VAL;
      1: frame_byte = HEADER_VAL;
      2: frame_byte = hs;
      3: frame_byte = link_ctrl;
      4: frame_byte = src_addr;
      5: frame_byte = dst_addr;
      6: frame_byte = 8'h3C;
      7: frame_byte = 8'hC3;
      default: frame_byte = hs + link_ctrl + src_addr + dst_addr + 8'h3C + 8'hC3;
    endcase
  endfunction

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Idle levels straight after reset
  task automatic t_reset();
    `CHK(serial_out, 1'b1)
    `CHK(rx_tx_n, 1'b1)
    `CHK({kick, tx_busy, empty_ev, tick_count}, {2'b10, 1'b0, 16'h0000})
  endtask

  // Tick spacing, count step and watchdog kick width
  task automatic t_tick();
    int n;
    logic [15:0] c0;
    n = 0;
    while (tick !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
    c0 = tick_count;
    n = 0;
    do begin @(negedge clk); n++; end while (tick !== 1'b1 && n < 1000);
    `CHK(n, TICKS)
    @(negedge clk);
    `CHK(tick_count, c0 + 16'h0001)
    n = 0;
    while (kick !== 1'b0 && n < 1000) begin @(negedge clk); n++; end
    n = 0;
    while (kick === 1'b0 && n < 1000) begin @(negedge clk); n++; end
    `CHK(n, KICK_CYCLES)
  endtask

  // One event on the carrier falling edge, none on its rise
  task automatic t_carrier();
    int cnt;
    cnt = 0;
    @(posedge clk) carrier_cmd <= 1'b1;
    repeat (10) begin @(negedge clk); cnt += (carrier_event === 1'b1); end
    `CHK(cnt, 1)
    cnt = 0;
    @(posedge clk) carrier_cmd <= 1'b0;
    repeat (10) begin @(negedge clk); cnt += (carrier_event === 1'b1); end
    `CHK(cnt, 0)
  endtask

  // Whole frame out, a refused second start, then a reset in mid-character
  task automatic t_tx();
    logic [7:0] b;
    logic good;
    int e0, n;
    e0 = n_empty;
    @(posedge clk) begin tx_wr <= 1'b1; tx_wr_idx <= 4'h0; tx_wr_data <= 8'h3C; end
    @(posedge clk) begin tx_wr_idx <= 4'h1; tx_wr_data <= 8'hC3; end
    @(posedge clk) begin tx_wr <= 1'b0; tx_len <= 5'h02; tx_start <= 1'b1; end
    @(posedge clk) tx_start <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      modem_u.recv_char(b, good);
      `CHK({b, good}, {frame_byte(i, house_addr), 1'b1})
      `CHK(rx_tx_n, 1'b0)
      if (i == 1) begin
        @(posedge clk) tx_start <= 1'b1;
        @(posedge clk) tx_start <= 1'b0;
      end
    end
    n = 0;
    while (tx_busy !== 1'b0 && n < 4 * BIT) begin @(negedge clk); n++; end
    repeat (BIT) @(negedge clk);
    `CHK({tx_busy, serial_out, rx_tx_n}, 3'b011)
    `CHK(n_empty - e0, 9)
    @(posedge clk) tx_start <= 1'b1;
    @(posedge clk) tx_start <= 1'b0;
    repeat (BIT * 3) @(negedge clk);
    `CHK({tx_busy, rx_tx_n}, 2'b10)
    @(posedge clk) rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK({serial_out, rx_tx_n, tx_busy}, 3'b110)
    @(posedge clk) rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK({serial_out, tx_busy, kick}, 3'b101)
  endtask

  // Frame in from the modem; flip picks a byte with bad parity, skew spoils the sum
  task automatic t_rx(input logic [7:0] hs, input int flip, input logic [7:0] skew,
                      input logic good);
    int d0, m0, k0, b0;
    logic [7:0] v;
    d0 = n_data;
    m0 = n_match;
    k0 = n_ok;
    b0 = n_bad;
    for (int i = 0; i < 9; i++) begin
      v = frame_byte(i, hs);
      if (i == 8) v = v + skew;
      modem_u.send_char(v, i == flip);
    end
    repeat (BIT) @(negedge clk);
    `CHK(n_data - d0, 9)
    `CHK(n_match - m0, 1)
    `CHK(n_ok - k0, int'(good))
    `CHK(n_bad - b0, int'(!good))
    if (good) begin
      `CHK(rx_len, 5'h02)
      @(posedge clk) rx_rd_idx <= 4'h1;
      @(negedge clk);
      `CHK(rx_rd_data, 8'hC3)
      @(posedge clk) rx_rd_idx <= 4'h0;
      @(negedge clk);
      `CHK(rx_rd_data, 8'h3C)
    end
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_reset();
    t_tick();
    t_carrier();
    t_tx();
    t_tick();
    t_rx(house_addr, 9, 8'h00, 1'b1);
    t_rx(8'h5B, 9, 8'h00, 1'b0);
    t_rx(house_addr, 6, 8'h00, 1'b0);
    t_rx(house_addr, 9, 8'h01, 1'b0);
    `CHK({modem_reset_out, short_kick, dir_timeout}, 3'b000)
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #200us;
    n_fail++;
    summarize();
  end
endmodule
